// File: include/mdc_defs.svh
// Constants of the multi-channel transfer controller
`ifndef MDC_DEFS_SVH
`define MDC_DEFS_SVH
`define MDC_NCH 12
`define MDC_NPER 10
`define MDC_NTX 5
`define MDC_NPID 20
`define MDC_TX_PID_LIM 5'h0A
`define MDC_REG_CTRL 4'h0
`define MDC_REG_STAT 4'h1
`define MDC_REG_BASE0 4'h2
`define MDC_REG_LEN0 4'h3
`define MDC_REG_BASE1 4'h4
`define MDC_REG_LEN1 4'h5
`define MDC_REG_DST 4'h6
`define MDC_C_EN 0
`define MDC_C_IRQ 1
`define MDC_C_ROLL 2
`define MDC_C_SINC 3
`define MDC_C_DINC 4
`define MDC_C_SIZE 6:5
`define MDC_C_PID 11:7
`define MDC_C_MODE 13:12
`define MDC_C_REQE 14
`define MDC_C_REQL 15
`define MDC_C_ACKL 16
`define MDC_C_EOTO 17
`define MDC_C_EOTL 18
`define MDC_C_START 31
`define MDC_SZ_BYTE 2'h0
`define MDC_SZ_WORD 2'h1
`define MDC_SZ_QUAD 2'h2
`define MDC_MODE_MEM 2'h0
`define MDC_MODE_TOEXT 2'h1
`define MDC_MODE_FROMEXT 2'h2
`define MDC_UNIT_BYTE 16'h0001
`define MDC_UNIT_WORD 16'h0004
`define MDC_UNIT_QUAD 16'h0010
`define MDC_QUAD_BEATS 2'h3
`define MDC_STEP_WORD 32'h0000_0004
`define MDC_STEP_BYTE 32'h0000_0001
`define MDC_BURST_SINGLE 1'b0
`define MDC_BURST_INCR 1'b1
`endif

// File: include/mdc_pkg.sv
// Types of the multi-channel transfer controller
package mdc_pkg;
  typedef logic [4:0] mdc_pid_t;
  typedef logic [3:0] mdc_ch_t;
  typedef enum logic [4:0] {
    MDC_IDLE = 5'h01,
    MDC_MRD = 5'h02,
    MDC_PRD = 5'h04,
    MDC_WR = 5'h08,
    MDC_DONE = 5'h10
  } mdc_state_e;
endpackage : mdc_pkg

// File: hw/mdc_dma.sv
// Multi-channel transfer controller: APB registers, one shared transfer engine
// Operation
// R01 - Five transmit and five receive peripheral channels
// R02 - Each channel maps to one of twenty sources
// R03 - Codec six channels, others one each way; the code allows only one enabled channel per source
// R04 - Two memory channels, optionally external peripheral
// R05 - Software start only on memory channels
// R06 - Separate source/destination, each increment or fixed
// R07 - Fill memory from one fixed source
// R08 - Two descriptors, automatic switch between them
// R09 - Buffer length independent of packet size
// R10 - Only incrementing bursts on the bus
// R11 - Byte, word, quad sizes; programmable
// R12 - Internal arbitration, external bus arbiter request
// R13 - Disabled channels have clock gated
// R14 - Maskable per-channel interrupt for descriptor update
// R15 - External request edge/level, high/low
// R16 - Peripheral holds or pulses its request
// R17 - Acknowledge polarity, pulses with bus strobes
// R18 - End pin direction, polarity; final count
// R19 - Peripheral gives end with final request
// R20 - Transfer ends on end pin or count
// R21 - Status: count reached, ended by peripheral
// R22 - End raises interrupt, optional descriptor rollover
// R23 - Bus granted only after current access
// R24 - No transfer unless enabled, valid length
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`include "mdc_defs.svh"
module mdc_dma (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mbus_req,
  input wire logic mbus_gnt,
  input wire logic mbus_ready,
  output logic [31:0] mbus_addr,
  output logic mbus_write,
  output logic [1:0] mbus_size,
  output logic mbus_burst,
  output logic [31:0] mbus_wdata,
  input wire logic [31:0] mbus_rdata,
  input wire logic [19:0] pdma_req,
  output mdc_pkg::mdc_pid_t pdma_sel,
  output logic pdma_rd,
  output logic pdma_wr,
  output logic [31:0] pdma_wdata,
  input wire logic [31:0] pdma_rdata,
  input wire logic [1:0] ext_transfer_request,
  output logic [1:0] ext_transfer_acknowledge,
  input wire logic [1:0] ext_terminal_or_end_pin_in,
  output logic [1:0] ext_terminal_or_end_pin_out,
  output logic [1:0] ext_terminal_or_end_pin_oe,
  input wire logic bus_output_enable_strobe_n,
  input wire logic bus_write_enable_strobe_n,
  output logic [11:0] chan_irq,
  output logic [11:0] chan_clk_en
);
  import mdc_pkg::*;

  logic [31:0] ctrl [`MDC_NCH];
  logic [31:0] base [`MDC_NCH][2];
  logic [15:0] len [`MDC_NCH][2];
  logic [31:0] dst [`MDC_NCH];
  logic [1:0] dval [`MDC_NCH];
  logic [11:0] cur;
  logic [11:0] go;
  logic [11:0] pend;
  logic [11:0] st_eq;
  logic [11:0] st_eot;
  logic [1:0] ext_prev;
  logic [1:0] ext_pend;
  logic [1:0] ext_act;
  logic [11:0] elig;
  mdc_state_e state;
  mdc_ch_t eng_ch;
  mdc_ch_t rr;
  mdc_ch_t pick;
  logic pick_ok;
  logic [31:0] a_src;
  logic [31:0] a_dst;
  logic [15:0] eng_rem;
  logic [15:0] unit;
  logic eng_eot;
  logic eng_final;
  logic [1:0] bcnt;
  logic [1:0] nbeat;
  logic [31:0] dbuf [4];
  logic accept;
  logic [31:0] step;
  logic ext_beat;
  logic [1:0] ext_k;
  logic wr_access;
  logic rd_setup;
  mdc_ch_t a_ch;
  logic [3:0] a_reg;
  logic a_ok;
  logic [31:0] rd_val;
  logic en_ok;

  assign a_ch = paddr[9:6];
  assign a_reg = paddr[5:2];
  assign a_ok = (a_ch < 4'(`MDC_NCH)) && (a_reg <= `MDC_REG_DST) && (paddr[11:10] == 2'h0);
  assign wr_access = psel & penable & pready & pwrite & a_ok;
  assign rd_setup = psel & ~penable;
  assign accept = mbus_req & mbus_gnt & mbus_ready;
  assign ext_k = eng_ch[1:0] - 2'h2;

  // Peripheral channels always move words, independent of packet size
  always_comb begin
    unit = `MDC_UNIT_WORD; // R09
    if (eng_ch >= 4'(`MDC_NPER)) begin
      case (ctrl[eng_ch][`MDC_C_SIZE])
        `MDC_SZ_BYTE: unit = `MDC_UNIT_BYTE; // R11
        `MDC_SZ_QUAD: unit = `MDC_UNIT_QUAD; // R11
        default: unit = `MDC_UNIT_WORD;
      endcase
    end
    step = (unit == `MDC_UNIT_BYTE) ? `MDC_STEP_BYTE : `MDC_STEP_WORD;
    eng_final = (eng_rem <= unit) | eng_eot; // R20
  end

  // Enabling a peripheral channel on a source already taken is refused
  always_comb begin
    en_ok = 1'b1;
    if (a_ch < 4'(`MDC_NPER)) begin
      if ((a_ch < 4'(`MDC_NTX)) != (pwdata[`MDC_C_PID] < `MDC_TX_PID_LIM)) begin
        en_ok = 1'b0; // R02
      end
      if (pwdata[`MDC_C_PID] >= 5'(`MDC_NPID)) begin
        en_ok = 1'b0; // R02
      end
      for (int c = 0; c < `MDC_NPER; c++) begin
        if (4'(c) != a_ch && ctrl[c][`MDC_C_EN] && ctrl[c][`MDC_C_PID] == pwdata[`MDC_C_PID]) begin
          en_ok = 1'b0; // R03
        end
      end
    end
  end

  always_comb begin
    for (int k = 0; k < 2; k++) begin
      ext_act[k] = ext_transfer_request[k] ^ ctrl[`MDC_NPER + k][`MDC_C_REQL]; // R15
    end
  end

  // Eligibility: enabled, current descriptor valid, a request present (a software start in memory mode)
  always_comb begin
    for (int c = 0; c < `MDC_NCH; c++) begin
      elig[c] = ctrl[c][`MDC_C_EN] & dval[c][cur[c]]; // R24
      if (c < `MDC_NPER) begin
        elig[c] = elig[c] & pdma_req[ctrl[c][`MDC_C_PID]]; // R01
      end else if (ctrl[c][`MDC_C_MODE] == `MDC_MODE_MEM) begin
        elig[c] = elig[c] & go[c]; // R05
      end else if (ctrl[c][`MDC_C_REQE]) begin
        elig[c] = elig[c] & ext_pend[c - `MDC_NPER]; // R16
      end else begin
        elig[c] = elig[c] & ext_act[c - `MDC_NPER]; // R16
      end
    end
  end

  // Round robin from the channel after the last one served
  always_comb begin
    int idx;
    idx = 0;
    pick = 4'h0;
    pick_ok = 1'b0;
    for (int i = `MDC_NCH; i >= 1; i--) begin
      idx = (int'(rr) + i) % `MDC_NCH;
      if (elig[idx]) begin
        pick = 4'(idx); // R12
        pick_ok = 1'b1;
      end
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    case (a_reg)
      `MDC_REG_CTRL: rd_val = {1'b0, ctrl[a_ch][30:0]};
      `MDC_REG_STAT: rd_val = {25'h0, (state != MDC_IDLE) && (eng_ch == a_ch), dval[a_ch],
                               cur[a_ch], st_eot[a_ch], st_eq[a_ch], pend[a_ch]}; // R21
      `MDC_REG_BASE0: rd_val = base[a_ch][0];
      `MDC_REG_LEN0: rd_val = {16'h0, len[a_ch][0]};
      `MDC_REG_BASE1: rd_val = base[a_ch][1];
      `MDC_REG_LEN1: rd_val = {16'h0, len[a_ch][1]};
      `MDC_REG_DST: rd_val = dst[a_ch];
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Read data is captured in setup so the access phase is one cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_setup;
      pslverr <= rd_setup & ~a_ok;
      if (rd_setup) begin
        prdata <= a_ok ? rd_val : 32'h0000_0000;
      end
    end
  end

  // Channel registers; engine write-back follows the bus so its sets win
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < `MDC_NCH; c++) begin
        ctrl[c] <= 32'h0000_0000;
        base[c][0] <= 32'h0000_0000;
        base[c][1] <= 32'h0000_0000;
        len[c][0] <= 16'h0000;
        len[c][1] <= 16'h0000;
        dst[c] <= 32'h0000_0000;
        dval[c] <= 2'h0;
      end
      cur <= 12'h000;
      go <= 12'h000;
      pend <= 12'h000;
      st_eq <= 12'h000;
      st_eot <= 12'h000;
    end else begin
      if (wr_access) begin
        case (a_reg)
          `MDC_REG_CTRL: begin
            ctrl[a_ch] <= {1'b0, pwdata[30:0]};
            ctrl[a_ch][`MDC_C_EN] <= pwdata[`MDC_C_EN] & en_ok;
            if (!pwdata[`MDC_C_EN]) begin
              go[a_ch] <= 1'b0;
            end else if (pwdata[`MDC_C_START] && a_ch >= 4'(`MDC_NPER)
                         && pwdata[`MDC_C_MODE] == `MDC_MODE_MEM) begin
              go[a_ch] <= 1'b1; // R05
            end
          end
          `MDC_REG_STAT: begin
            pend <= pend & ~(12'(pwdata[0]) << a_ch);
          end
          `MDC_REG_BASE0: base[a_ch][0] <= pwdata;
          `MDC_REG_LEN0: begin
            len[a_ch][0] <= pwdata[15:0];
            dval[a_ch][0] <= (pwdata[15:0] != 16'h0000); // R24
          end
          `MDC_REG_BASE1: base[a_ch][1] <= pwdata;
          `MDC_REG_LEN1: begin
            len[a_ch][1] <= pwdata[15:0];
            dval[a_ch][1] <= (pwdata[15:0] != 16'h0000); // R08
          end
          `MDC_REG_DST: dst[a_ch] <= pwdata; // R06
          default: begin
          end
        endcase
      end
      if (state == MDC_DONE) begin
        if (eng_ch < 4'(`MDC_NTX) || eng_ch >= 4'(`MDC_NPER)) begin
          base[eng_ch][cur[eng_ch]] <= a_src;
        end else begin
          base[eng_ch][cur[eng_ch]] <= a_dst;
        end
        if (eng_ch >= 4'(`MDC_NPER)) begin
          dst[eng_ch] <= a_dst;
        end
        len[eng_ch][cur[eng_ch]] <= eng_final ? 16'h0000 : eng_rem - unit;
        if (eng_final) begin
          dval[eng_ch][cur[eng_ch]] <= 1'b0;
          pend[eng_ch] <= 1'b1; // R22
          st_eq[eng_ch] <= (eng_rem <= unit); // R21
          st_eot[eng_ch] <= eng_eot; // R21
          if (ctrl[eng_ch][`MDC_C_ROLL] && dval[eng_ch][~cur[eng_ch]]) begin
            cur[eng_ch] <= ~cur[eng_ch]; // R08
          end else begin
            go[eng_ch] <= 1'b0;
          end
        end
      end
    end
  end

  // Edge-mode request is held until the engine takes it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ext_prev <= 2'h0;
      ext_pend <= 2'h0;
    end else begin
      ext_prev <= ext_act;
      for (int k = 0; k < 2; k++) begin
        if (state == MDC_IDLE && pick_ok && pick == 4'(`MDC_NPER + k)) begin
          ext_pend[k] <= 1'b0;
        end
        if (ext_act[k] && !ext_prev[k]) begin
          ext_pend[k] <= 1'b1; // R15
        end
      end
    end
  end

  // Transfer engine: read one unit into the buffer, then write it out
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= MDC_IDLE;
      eng_ch <= 4'h0;
      rr <= 4'h0;
      a_src <= 32'h0000_0000;
      a_dst <= 32'h0000_0000;
      eng_rem <= 16'h0000;
      eng_eot <= 1'b0;
      bcnt <= 2'h0;
      nbeat <= 2'h0;
      for (int i = 0; i < 4; i++) begin
        dbuf[i] <= 32'h0000_0000;
      end
      mbus_req <= 1'b0;
      mbus_addr <= 32'h0000_0000;
      mbus_write <= 1'b0;
      mbus_size <= `MDC_SZ_WORD;
      mbus_burst <= `MDC_BURST_SINGLE;
      mbus_wdata <= 32'h0000_0000;
      pdma_sel <= 5'h00;
      pdma_rd <= 1'b0;
      pdma_wr <= 1'b0;
      pdma_wdata <= 32'h0000_0000;
    end else begin
      pdma_rd <= 1'b0;
      pdma_wr <= 1'b0;
      case (state)
        MDC_IDLE: begin
          if (pick_ok) begin
            eng_ch <= pick;
            rr <= pick; // R12
            eng_rem <= len[pick][cur[pick]];
            a_src <= base[pick][cur[pick]];
            a_dst <= (pick >= 4'(`MDC_NPER)) ? dst[pick] : base[pick][cur[pick]];
            pdma_sel <= ctrl[pick][`MDC_C_PID];
            nbeat <= (pick >= 4'(`MDC_NPER) && ctrl[pick][`MDC_C_SIZE] == `MDC_SZ_QUAD)
                     ? `MDC_QUAD_BEATS : 2'h0;
            bcnt <= 2'h0;
            eng_eot <= (pick >= 4'(`MDC_NPER)) && ctrl[pick][`MDC_C_MODE] != `MDC_MODE_MEM
                       && !ctrl[pick][`MDC_C_EOTO]
                       && (ext_terminal_or_end_pin_in[pick[0]] ^ ctrl[pick][`MDC_C_EOTL]); // R19
            if (pick >= 4'(`MDC_NTX) && pick < 4'(`MDC_NPER)) begin
              state <= MDC_PRD;
              pdma_rd <= 1'b1;
            end else begin
              state <= MDC_MRD;
            end
          end
        end
        MDC_PRD: begin
          dbuf[0] <= pdma_rdata;
          state <= MDC_WR;
        end
        MDC_MRD: begin
          if (!mbus_req) begin
            mbus_req <= 1'b1;
            mbus_write <= 1'b0;
            mbus_addr <= a_src;
            mbus_size <= (unit == `MDC_UNIT_BYTE) ? `MDC_SZ_BYTE : `MDC_SZ_WORD;
            mbus_burst <= (nbeat != 2'h0) ? `MDC_BURST_INCR : `MDC_BURST_SINGLE; // R10
          end else if (accept) begin
            dbuf[bcnt] <= mbus_rdata;
            bcnt <= bcnt + 2'h1;
            if (eng_ch < 4'(`MDC_NPER) || ctrl[eng_ch][`MDC_C_SINC]) begin
              a_src <= a_src + step; // R06
            end
            mbus_addr <= mbus_addr + step;
            if (bcnt == nbeat) begin
              mbus_req <= 1'b0; // R23
              bcnt <= 2'h0;
              state <= MDC_WR;
            end
          end
        end
        MDC_WR: begin
          if (eng_ch < 4'(`MDC_NTX)) begin
            pdma_wr <= 1'b1;
            pdma_wdata <= dbuf[0];
            state <= MDC_DONE;
          end else if (!mbus_req) begin
            mbus_req <= 1'b1;
            mbus_write <= 1'b1;
            mbus_addr <= a_dst;
            mbus_wdata <= dbuf[bcnt];
          end else if (accept) begin
            bcnt <= bcnt + 2'h1;
            mbus_wdata <= dbuf[bcnt + 2'h1];
            mbus_addr <= mbus_addr + step;
            if (eng_ch < 4'(`MDC_NPER) || ctrl[eng_ch][`MDC_C_DINC]) begin
              a_dst <= a_dst + step; // R07
            end
            if (bcnt == nbeat) begin
              mbus_req <= 1'b0; // R23
              state <= MDC_DONE;
            end
          end
        end
        MDC_DONE: begin
          state <= MDC_IDLE;
        end
        default: state <= MDC_IDLE;
      endcase
    end
  end

  // External side of a unit: write beat to the device, or read beat from it
  always_comb begin
    ext_beat = 1'b0;
    if (eng_ch >= 4'(`MDC_NPER) && mbus_req) begin
      ext_beat = (ctrl[eng_ch][`MDC_C_MODE] == `MDC_MODE_TOEXT && state == MDC_WR)
                 || (ctrl[eng_ch][`MDC_C_MODE] == `MDC_MODE_FROMEXT && state == MDC_MRD); // R04
    end
  end

  // Handshake pins follow the bus strobes, one cycle later as registered outputs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ext_transfer_acknowledge <= 2'h0;
      ext_terminal_or_end_pin_out <= 2'h0;
      ext_terminal_or_end_pin_oe <= 2'h0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        ext_transfer_acknowledge[k] <= ctrl[`MDC_NPER + k][`MDC_C_ACKL]
          ^ (ext_beat && ext_k == 2'(k)
             && !(bus_output_enable_strobe_n && bus_write_enable_strobe_n)); // R17
        ext_terminal_or_end_pin_out[k] <= ctrl[`MDC_NPER + k][`MDC_C_EOTL]
          ^ (ext_beat && ext_k == 2'(k) && eng_rem <= unit
             && !(bus_output_enable_strobe_n && bus_write_enable_strobe_n)); // R18
        ext_terminal_or_end_pin_oe[k] <= ctrl[`MDC_NPER + k][`MDC_C_EN]
          & ctrl[`MDC_NPER + k][`MDC_C_EOTO]; // R18
      end
    end
  end

  // Clock enables follow each channel's enable bit, so only disabled channels are gated
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chan_irq <= 12'h000;
      chan_clk_en <= 12'h000;
    end else begin
      for (int c = 0; c < `MDC_NCH; c++) begin
        chan_irq[c] <= pend[c] & ctrl[c][`MDC_C_IRQ]; // R14
        chan_clk_en[c] <= ctrl[c][`MDC_C_EN]; // R13
      end
    end
  end
endmodule : mdc_dma

// File: verification/mdc_dma_monitor.sv
// Port-level checks of the transfer controller
`timescale 1ns/1ns
module mdc_dma_monitor (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mbus_req,
  input wire logic mbus_gnt,
  input wire logic mbus_ready,
  input wire logic [31:0] mbus_addr,
  input wire logic mbus_write,
  input wire logic mbus_burst,
  input wire logic pdma_rd,
  input wire logic pdma_wr,
  input wire logic [11:0] chan_clk_en
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence burst_beat_s;
    mbus_req && mbus_gnt && mbus_ready && mbus_burst;
  endsequence
  sequence apb_setup_s;
    psel && !penable;
  endsequence
  req_hold_a: assert property (
    mbus_req && !(mbus_gnt && mbus_ready) |=> mbus_req && $stable(mbus_addr) && $stable(mbus_write))
    else $error("Bus request changed before its beat");
  incr_burst_a: assert property (
    burst_beat_s ##1 (mbus_req && mbus_burst) |-> mbus_addr == $past(mbus_addr) + 32'h4)
    else $error("Burst address did not increment by one word");
  // Three idle cycles cover the raise latency of the request
  gated_quiet_a: assert property (
    chan_clk_en == 12'h000 && $past(chan_clk_en) == 12'h000 && $past(chan_clk_en, 2) == 12'h000
    |-> !mbus_req && !pdma_rd && !pdma_wr)
    else $error("Traffic with every channel disabled");
  rd_pulse_a: assert property (pdma_rd |=> !pdma_rd)
    else $error("Peripheral read strobe longer than one cycle");
  wr_pulse_a: assert property (pdma_wr |=> !pdma_wr)
    else $error("Peripheral write strobe longer than one cycle");
  rx_write_a: assert property (pdma_rd |-> ##[2:60] (mbus_req && mbus_write))
    else $error("Received word never written to memory");
  apb_answer_a: assert property (apb_setup_s |=> pready ##1 !pready)
    else $error("Register access not answered in one cycle");
  unmapped_a: assert property (
    psel && !penable && paddr[11:10] != 2'h0 |=> pready && pslverr)
    else $error("Unmapped access not flagged");
endmodule : mdc_dma_monitor

bind mdc_dma mdc_dma_monitor chk (
  .core_clk, .rst, .paddr, .psel, .penable, .pready, .pslverr, .mbus_req, .mbus_gnt,
  .mbus_ready, .mbus_addr, .mbus_write, .mbus_burst, .pdma_rd, .pdma_wr, .chan_clk_en
);

// File: verification/mdc_far_model.sv
// Memory, peripheral data source and bus strobes at the controller's far side
`timescale 1ns/1ns
module mdc_far_model #(
  parameter logic [31:0] PVAL = 32'h5A5A_0C0C
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic mbus_req,
  input wire logic [31:0] mbus_addr,
  input wire logic mbus_write,
  input wire logic [31:0] mbus_wdata,
  output logic mbus_gnt,
  output logic mbus_ready,
  output logic [31:0] mbus_rdata,
  input wire logic pdma_rd,
  output logic [31:0] pdma_rdata,
  output logic oe_n,
  output logic we_n
);
  logic [31:0] mem [0:255];
  logic tick;
  // Grant lags the request, as a shared arbiter would
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mbus_gnt <= 1'b0;
      tick <= 1'b0;
    end else begin
      mbus_gnt <= mbus_req;
      tick <= ~tick;
    end
  end
  always @(posedge core_clk) begin
    if (mbus_req && mbus_gnt && mbus_ready && mbus_write) begin
      mem[mbus_addr[9:2]] <= mbus_wdata;
    end
  end
  assign mbus_ready = mbus_gnt && (!slow || tick);
  // Outside a beat the data is inverted so a stale value never passes
  assign mbus_rdata = mbus_ready ? mem[mbus_addr[9:2]] : ~mem[mbus_addr[9:2]];
  // Data stands while the read strobe is high, the controller samples it at that edge
  assign pdma_rdata = pdma_rd ? PVAL : ~PVAL;
  assign oe_n = !(mbus_gnt && !mbus_write);
  assign we_n = !(mbus_gnt && mbus_write);
endmodule : mdc_far_model

// File: verification/mdc_dma_test.sv
// Self-checking bench of the transfer controller
`timescale 1ns/1ns
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin errors++; $display("Error at %0t: got %h expected %h", $time, g, x); end end
module mdc_dma_test;
  import mdc_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic mbus_req;
  logic mbus_gnt;
  logic mbus_ready;
  logic mbus_write;
  logic mbus_burst;
  logic [31:0] mbus_addr;
  logic [31:0] mbus_wdata;
  logic [31:0] mbus_rdata;
  logic [31:0] pdma_rdata;
  logic [1:0] mbus_size;
  logic [1:0] ack;
  logic [1:0] end_out;
  logic [1:0] end_oe;
  logic [19:0] pdma_req = 20'h0;
  mdc_pid_t pdma_sel;
  logic pdma_rd;
  logic pdma_wr;
  logic oe_n;
  logic we_n;
  logic slow = 1'b0;
  logic [1:0] ext_req = 2'h0;
  logic [11:0] chan_irq;
  logic [11:0] chan_clk_en;
  logic [31:0] pdma_wdata;
  logic [31:0] tx_word;
  mdc_pid_t tx_sel;
  logic [1:0] end_in = 2'h0;
  logic [31:0] q;
  logic e;
  int errors = 0;
  int checked = 0;
  int ack_n = 0;
  int tc_n = 0;

  always #10 core_clk = ~core_clk;

  mdc_dma uut (
    .core_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .mbus_req, .mbus_gnt, .mbus_ready, .mbus_addr, .mbus_write, .mbus_size, .mbus_burst,
    .mbus_wdata, .mbus_rdata, .pdma_req, .pdma_sel, .pdma_rd, .pdma_wr, .pdma_wdata,
    .pdma_rdata, .ext_transfer_request(ext_req), .ext_transfer_acknowledge(ack),
    .ext_terminal_or_end_pin_in(end_in), .ext_terminal_or_end_pin_out(end_out),
    .ext_terminal_or_end_pin_oe(end_oe), .bus_output_enable_strobe_n(oe_n),
    .bus_write_enable_strobe_n(we_n), .chan_irq, .chan_clk_en
  );

  mdc_far_model far (
    .core_clk, .rst, .slow, .mbus_req, .mbus_addr, .mbus_write, .mbus_wdata, .mbus_gnt,
    .mbus_ready, .mbus_rdata, .pdma_rd, .pdma_rdata, .oe_n, .we_n
  );

  always @(posedge core_clk) begin
    if (ack[1] === 1'b1) ack_n++;
    if (ack[1] === 1'b1 && end_oe[1] === 1'b1 && end_out[1] === 1'b1) tc_n++;
    if (pdma_wr === 1'b1) begin
      tx_word <= pdma_wdata;
      tx_sel <= pdma_sel;
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Polls status until pending; a hang is left to the watchdog
  task automatic wait_pend(input logic [11:0] ch);
    do begin
      apb(1'b0, ch + 12'h004, 32'h0);
    end while (q[0] !== 1'b1);
  endtask : wait_pend

  task automatic mem_run(input logic [11:0] ch, input logic [31:0] src, input logic [31:0] len,
                         input logic [31:0] dst, input logic [31:0] ctrl);
    apb(1'b1, ch + 12'h008, src);
    apb(1'b1, ch + 12'h00C, len);
    apb(1'b1, ch + 12'h018, dst);
    apb(1'b1, ch, ctrl);
    wait_pend(ch);
  endtask : mem_run

  task final_report;
    $display("Checks %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  initial begin
    #1_000_000;
    errors++;
    final_report();
  end

  initial begin
    for (int i = 0; i < 256; i++) far.mem[i] = 32'hA000_0000 + i;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    apb(1'b0, 12'h280, 32'h0);
    `CHK(q, 32'h0)
    `CHK(chan_clk_en, 12'h000)
    apb(1'b0, 12'hC00, 32'h0);
    `CHK({e, q}, 33'h1_0000_0000)
    $display("Reset test done");
    mem_run(12'h280, 32'h0, 32'h8, 32'h100, 32'h8000_003B);
    `CHK(q[1:0], 2'h3)
    `CHK(chan_irq[10], 1'b1)
    `CHK(far.mem[64], 32'hA000_0000)
    `CHK(far.mem[65], 32'hA000_0001)
    apb(1'b1, 12'h284, 32'h1);
    repeat (3) @(posedge core_clk);
    `CHK(chan_irq[10], 1'b0)
    $display("Copy test done");
    slow <= 1'b1;
    mem_run(12'h2C0, 32'h10, 32'hC, 32'h140, 32'h8000_0031);
    for (int i = 80; i < 83; i++) `CHK(far.mem[i], 32'hA000_0004)
    `CHK(chan_irq[11], 1'b0)
    apb(1'b1, 12'h2C4, 32'h1);
    slow <= 1'b0;
    $display("Fill test done");
    mem_run(12'h280, 32'h20, 32'h10, 32'h180, 32'h8000_005B);
    for (int i = 0; i < 4; i++) `CHK(far.mem[96 + i], 32'hA000_0008 + i)
    apb(1'b1, 12'h284, 32'h1);
    $display("Quad test done");
    apb(1'b1, 12'h000, 32'h0000_0A01);
    apb(1'b0, 12'h000, 32'h0);
    `CHK(q[0], 1'b0)
    `CHK(chan_clk_en[0], 1'b0)
    apb(1'b1, 12'h148, 32'h200);
    apb(1'b1, 12'h14C, 32'h4);
    apb(1'b1, 12'h140, 32'h0000_0623);
    pdma_req <= 20'h0_1000;
    wait_pend(12'h140);
    pdma_req <= 20'h0;
    `CHK(far.mem[128], far.PVAL)
    `CHK(chan_clk_en[5], 1'b1)
    apb(1'b1, 12'h144, 32'h1);
    apb(1'b1, 12'h008, 32'h4);
    apb(1'b1, 12'h00C, 32'h4);
    apb(1'b1, 12'h000, 32'h0000_0183);
    pdma_req <= 20'h0_0008;
    wait_pend(12'h000);
    pdma_req <= 20'h0;
    `CHK(tx_word, 32'hA000_0001)
    `CHK(tx_sel, 5'h03)
    $display("Peripheral test done");
    ext_req <= 2'h2;
    mem_run(12'h2C0, 32'h0, 32'h4, 32'h0, 32'h0002_102B);
    ext_req <= 2'h0;
    `CHK(q[1], 1'b1)
    `CHK(ack_n > 0, 1'b1)
    `CHK(tc_n > 0, 1'b1)
    $display("External test done");
    apb(1'b1, 12'h2C4, 32'h1);
    ext_req <= 2'h2;
    end_in <= 2'h2;
    apb(1'b1, 12'h2C0, 32'h0005_A02B);
    apb(1'b1, 12'h2CC, 32'h8);
    ext_req <= 2'h0;
    end_in <= 2'h0;
    wait_pend(12'h2C0);
    `CHK(q[2:1], 2'h2)
    `CHK(far.mem[0], 32'hA000_0001)
    `CHK({end_oe[1], ack[1]}, 2'h1)
    $display("End pin test done");
    final_report();
  end
endmodule : mdc_dma_test
